// ---- inc/rmu_pkg.sv ----
// rmu_pkg: shared constants and carrier types for the real-mode address and stack unit
package rmu_pkg;

  // ==========================================================
  // address formation
  localparam int SEL_SHIFT = 4;               // selector to base shift
  localparam int PADDR_W = 21;                // 20-bit base plus kept carry
  localparam logic [31:0] OFS_LIMIT = 32'h0000FFFF; // highest legal offset
  localparam int WRAP_BIT = 20;               // line forced low by the wrap mask

  // ==========================================================
  // fault vectors
  localparam logic [7:0] VEC_STACK_FLT = 8'h0C; // stack segment overrun
  localparam logic [7:0] VEC_GEN_FLT = 8'h0D;   // any other segment overrun

  // ==========================================================
  // vector table
  localparam int VEC_SCALE_SH = 2;            // entries are 4 bytes
  localparam logic [31:0] VTAB_BASE_RST = 32'h00000000;
  localparam logic [15:0] VTAB_LIMIT_RST = 16'h03FF;

  // ==========================================================
  // reset values of architectural state
  localparam logic [15:0] CODE_SEL_RST = 16'hF000;
  localparam logic [31:0] IP_RST = 32'h0000FFF0;
  localparam logic [31:0] FLAGS_RST = 32'h00000002;
  localparam logic [15:0] STK_RST = 16'h0000;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_REAL = 2'b01,
    MODE_PROT = 2'b10
  } rmu_mode_t;

  // segment choice for an access
  typedef enum logic [2:0] {
    SEG_CODE = 3'h0,
    SEG_DATA = 3'h1,
    SEG_EXTRA = 3'h2,
    SEG_STACK = 3'h3,
    SEG_AUX1 = 3'h4,
    SEG_AUX2 = 3'h5
  } rmu_seg_t;

  // control transfer commands
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_CALL_NEAR = 3'h1,
    CMD_CALL_FAR = 3'h2,
    CMD_RET_NEAR = 3'h3,
    CMD_RET_FAR = 3'h4,
    CMD_INT = 3'h5,
    CMD_HANDLER_RETURN = 3'h6,
    CMD_LDVT = 3'h7
  } rmu_cmd_t;

  // memory access request from the execution side
  typedef struct packed {
    logic valid;
    logic is_fetch;
    logic addr32;       // address-size override
    rmu_seg_t seg;
    logic [31:0] offset;
  } rmu_acc_t;

  // physical access toward memory
  typedef struct packed {
    logic valid;
    logic write;
    logic [PADDR_W-1:0] addr;
    logic [15:0] wdata;
  } rmu_mem_t;

endpackage : rmu_pkg

// ---- verilog/rmu_core.sv ----
// rmu_core: real-mode address formation, offset check and stack frame sequencer
module rmu_core
  import rmu_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // access request and wrap mask
  input rmu_acc_t acc_in,
  input wire logic bit20_wrap_mask_n,
  input wire logic [1:0] op_size_in,     // 0 byte, 1 word, 2 dword
  input wire logic op32_prefix,
  // control transfer command
  input rmu_cmd_t cmd_in,
  input wire logic [31:0] cmd_target,    // new pointer, or table base for reload
  input wire logic [15:0] cmd_sel,       // new code selector
  input wire logic [7:0] cmd_vector,
  // memory answer
  input wire logic mem_ready,
  input wire logic [15:0] mem_rdata,
  // memory request
  output rmu_mem_t mem_out,
  // status
  output rmu_mode_t mode_q,
  output logic fault_q,
  output logic [7:0] fault_vec_q,
  output logic busy_q,
  output logic op_wide_q,
  output logic fpu_en_q,
  output logic [15:0] legacy_instr_ptr_q,
  output logic [15:0] status_word_q,
  output logic [15:0] stack_offset_q,
  output logic [15:0] code_seg_q
);

  // ==========================================================
  // segment selectors and architectural state
  logic [15:0] code_seg_sel_q;        // code selector
  logic [15:0] data_seg_sel_q;        // default data selector
  logic [15:0] extra_seg_sel_q;       // string destination selector
  logic [15:0] stack_seg_sel_q;       // stack selector
  logic [15:0] aux_seg_sel_one_q;     // extra selector, explicit only
  logic [15:0] aux_seg_sel_two_q;     // extra selector, explicit only
  logic [31:0] instr_ptr_ext_q;       // extended instruction pointer
  logic [31:0] status_word_ext_q;     // extended flags
  logic [15:0] stack_offset_reg_q;    // stack pointer offset
  logic [31:0] vtab_base_q;           // vector table base
  // the limit is held after reset but dispatch does not check it
  logic [15:0] vtab_limit_q;          // vector table limit

  // stack sequencer state
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_PUSH = 5'b00010,
    ST_POP = 5'b00100,
    ST_VEC = 5'b01000,
    ST_DATA = 5'b10000
  } rmu_st_t;
  rmu_st_t st_q;
  rmu_cmd_t cur_cmd_q;                // command being sequenced
  logic [1:0] step_q;                 // word index within a frame
  logic [1:0] nwords_q;               // words in this frame minus one
  logic [31:0] tgt_q;                 // latched target pointer
  logic [15:0] tsel_q;                // latched target selector
  logic [7:0] vec_q;                  // latched vector

  // ==========================================================
  // physical address formation
  // the wrap mask is read live, so a change applies to the very next request
  function automatic logic [PADDR_W-1:0] phys(input logic [15:0] sel, input logic [15:0] ofs);
    logic [PADDR_W-1:0] base;
    logic [PADDR_W-1:0] sum;
    base = {1'b0, sel, {SEL_SHIFT{1'b0}}};
    sum = base + {5'h00, ofs};
    if (!bit20_wrap_mask_n) begin
      sum[WRAP_BIT] = 1'b0;
    end
    return sum;
  endfunction : phys

  // selector chosen for a data access; fetch always uses code
  logic [15:0] acc_sel;
  always_comb begin
    acc_sel = data_seg_sel_q;
    if (acc_in.is_fetch) begin
      acc_sel = code_seg_sel_q;
    end else begin
      unique case (acc_in.seg)
        SEG_CODE: acc_sel = code_seg_sel_q;
        SEG_EXTRA: acc_sel = extra_seg_sel_q;
        SEG_STACK: acc_sel = stack_seg_sel_q;
        SEG_AUX1: acc_sel = aux_seg_sel_one_q;
        SEG_AUX2: acc_sel = aux_seg_sel_two_q;
        default: acc_sel = data_seg_sel_q;
      endcase
    end
  end

  // offset range check; a 16-bit offset can never overrun
  logic ofs_bad;
  assign ofs_bad = acc_in.addr32 && (acc_in.offset > OFS_LIMIT);

  // stack frame word addresses
  logic [15:0] push_ofs;
  assign push_ofs = stack_offset_reg_q - 16'h0002;
  // table entry address: the vector scaled by the entry size
  logic [31:0] vec_addr;
  assign vec_addr = vtab_base_q + ({24'h000000, vec_q} << VEC_SCALE_SH);

  // ==========================================================
  // mode: only reset touches it, and nothing in the unit switches it to protected
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q <= MODE_REAL;
    end
  end

  // float unit enable is independent of mode
  always_ff @(posedge mclk) begin
    if (srst) begin
      fpu_en_q <= 1'b1;
    end
  end

  // operand width: wide only with the prefix, else 8 or 16
  always_ff @(posedge mclk) begin
    if (srst) begin
      op_wide_q <= 1'b0;
    end else if (acc_in.valid) begin
      op_wide_q <= op32_prefix && (op_size_in == 2'd2);
    end
  end

  // ==========================================================
  // sequencer: ordinary accesses in idle, frames word by word
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      cur_cmd_q <= CMD_NONE;
      step_q <= 2'd0;
      nwords_q <= 2'd0;
      tgt_q <= 32'h00000000;
      tsel_q <= 16'h0000;
      vec_q <= 8'h00;
      busy_q <= 1'b0;
      mem_out <= '0;
      fault_q <= 1'b0;
      fault_vec_q <= 8'h00;
      code_seg_sel_q <= CODE_SEL_RST;
      data_seg_sel_q <= 16'h0000;
      extra_seg_sel_q <= 16'h0000;
      stack_seg_sel_q <= 16'h0000;
      aux_seg_sel_one_q <= 16'h0000;
      aux_seg_sel_two_q <= 16'h0000;
      instr_ptr_ext_q <= IP_RST;
      status_word_ext_q <= FLAGS_RST;
      stack_offset_reg_q <= STK_RST;
      vtab_base_q <= VTAB_BASE_RST;
      vtab_limit_q <= VTAB_LIMIT_RST;
    end else begin
      fault_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          mem_out <= '0;
          if (cmd_in != CMD_NONE) begin
            cur_cmd_q <= cmd_in;
            tgt_q <= cmd_target;
            tsel_q <= cmd_sel;
            vec_q <= cmd_vector;
            step_q <= 2'd0;
            busy_q <= 1'b1;
            unique case (cmd_in)
              CMD_CALL_NEAR: begin
                nwords_q <= 2'd0;
                st_q <= ST_PUSH;
              end
              CMD_CALL_FAR: begin
                nwords_q <= 2'd1;
                st_q <= ST_PUSH;
              end
              CMD_INT: begin
                nwords_q <= 2'd2;
                st_q <= ST_PUSH;
              end
              CMD_RET_NEAR: begin
                nwords_q <= 2'd0;
                st_q <= ST_POP;
              end
              CMD_RET_FAR: begin
                nwords_q <= 2'd1;
                st_q <= ST_POP;
              end
              CMD_HANDLER_RETURN: begin
                nwords_q <= 2'd2;
                st_q <= ST_POP;
              end
              default: begin
                vtab_base_q <= cmd_target;
                busy_q <= 1'b0;
                st_q <= ST_IDLE;
              end
            endcase
          end else if (acc_in.valid) begin
            if (ofs_bad) begin
              // access is dropped, no memory cycle issued
              fault_q <= 1'b1;
              fault_vec_q <= (acc_in.seg == SEG_STACK) ? VEC_STACK_FLT : VEC_GEN_FLT;
            end else begin
              mem_out.valid <= 1'b1;
              mem_out.write <= 1'b0;
              mem_out.addr <= phys(acc_sel, acc_in.offset[15:0]);
              busy_q <= 1'b1;
              st_q <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // plain access: hold the request until memory answers
          if (mem_ready) begin
            mem_out.valid <= 1'b0;
            busy_q <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        ST_PUSH: begin
          // pushes go flags, selector, pointer, so the pointer ends lowest
          mem_out.valid <= 1'b1;
          mem_out.write <= 1'b1;
          mem_out.addr <= phys(stack_seg_sel_q, push_ofs);
          if ((nwords_q - step_q) == 2'd2) begin
            mem_out.wdata <= status_word_ext_q[15:0];
          end else if ((nwords_q - step_q) == 2'd1) begin
            mem_out.wdata <= code_seg_sel_q;
          end else begin
            mem_out.wdata <= instr_ptr_ext_q[15:0];
          end
          if (mem_out.valid && mem_ready) begin
            mem_out.valid <= 1'b0;
            stack_offset_reg_q <= push_ofs;
            if (step_q == nwords_q) begin
              if (cur_cmd_q == CMD_INT) begin
                step_q <= 2'd0;
                st_q <= ST_VEC;
              end else begin
                instr_ptr_ext_q <= tgt_q;
                if (cur_cmd_q == CMD_CALL_FAR) begin
                  code_seg_sel_q <= tsel_q;
                end
                busy_q <= 1'b0;
                st_q <= ST_IDLE;
              end
            end else begin
              step_q <= step_q + 2'd1;
            end
          end
        end
        ST_POP: begin
          // pops come back pointer, selector, flags
          // the pointer's high half is cleared on pop
          mem_out.valid <= 1'b1;
          mem_out.write <= 1'b0;
          mem_out.addr <= phys(stack_seg_sel_q, stack_offset_reg_q);
          if (mem_out.valid && mem_ready) begin
            mem_out.valid <= 1'b0;
            stack_offset_reg_q <= stack_offset_reg_q + 16'h0002;
            if (step_q == 2'd0) begin
              instr_ptr_ext_q <= {16'h0000, mem_rdata};
            end else if (step_q == 2'd1) begin
              code_seg_sel_q <= mem_rdata;
            end else begin
              status_word_ext_q[15:0] <= mem_rdata;
            end
            if (step_q == nwords_q) begin
              busy_q <= 1'b0;
              st_q <= ST_IDLE;
            end else begin
              step_q <= step_q + 2'd1;
            end
          end
        end
        ST_VEC: begin
          // word 0 of the entry is the offset, word 1 the selector
          mem_out.valid <= 1'b1;
          mem_out.write <= 1'b0;
          mem_out.addr <= vec_addr[PADDR_W-1:0] + {{(PADDR_W-2){1'b0}}, step_q[0], 1'b0};
          if (mem_out.valid && mem_ready) begin
            mem_out.valid <= 1'b0;
            if (step_q == 2'd0) begin
              instr_ptr_ext_q <= {16'h0000, mem_rdata};
              step_q <= 2'd1;
            end else begin
              code_seg_sel_q <= mem_rdata;
              busy_q <= 1'b0;
              st_q <= ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // legacy 16-bit views, registered for the outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      legacy_instr_ptr_q <= IP_RST[15:0];
      status_word_q <= FLAGS_RST[15:0];
      stack_offset_q <= STK_RST;
      code_seg_q <= CODE_SEL_RST;
    end else begin
      legacy_instr_ptr_q <= instr_ptr_ext_q[15:0];
      status_word_q <= status_word_ext_q[15:0];
      stack_offset_q <= stack_offset_reg_q;
      code_seg_q <= code_seg_sel_q;
    end
  end

endmodule : rmu_core

// ---- verif/rmu_core_chk.sv ----
// rmu_core_chk: port-level assertions for the real-mode unit
module rmu_core_chk
  import rmu_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // requests
  input rmu_acc_t acc_in,
  input wire logic bit20_wrap_mask_n,
  input rmu_cmd_t cmd_in,
  input wire logic mem_ready,
  // outputs watched
  input rmu_mem_t mem_out,
  input rmu_mode_t mode_q,
  input wire logic fault_q,
  input wire logic [7:0] fault_vec_q,
  input wire logic busy_q,
  input wire logic fpu_en_q,
  input wire logic [15:0] legacy_instr_ptr_q,
  input wire logic [15:0] code_seg_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========================================
  // helpers: a taken access, its address and its range fault
  wire ok_acc = !busy_q && cmd_in == CMD_NONE && acc_in.valid;
  wire bad_acc = ok_acc && acc_in.addr32 && acc_in.offset > OFS_LIMIT;
  wire ok_fetch = ok_acc && acc_in.is_fetch && acc_in.offset <= OFS_LIMIT;
  wire [20:0] sum = {1'b0, code_seg_q, 4'h0} + {5'h00, acc_in.offset[15:0]};
  // ==========================================
  // assertions
  mode_real_a: assert property (mode_q == MODE_REAL)
    else $error("mode left real");
  fpu_on_a: assert property (fpu_en_q)
    else $error("fpu off");
  addr_full_a: assert property (ok_fetch && bit20_wrap_mask_n |=> mem_out.valid && mem_out.addr == $past(sum))
    else $error("full address wrong");
  addr_wrap_a: assert property (ok_fetch && !bit20_wrap_mask_n |=> mem_out.addr == {1'b0, $past(sum[19:0])})
    else $error("masked address wrong");
  fault_ofs_a: assert property (bad_acc |=> fault_q && !mem_out.valid &&
    fault_vec_q == ($past(acc_in.seg) == SEG_STACK ? VEC_STACK_FLT : VEC_GEN_FLT)) else $error("no fault");
  fault_cause_a: assert property (fault_q |-> $past(bad_acc))
    else $error("fault without cause");
  push_ip_a: assert property (!busy_q && cmd_in == CMD_CALL_NEAR |=> ##1
    mem_out.valid && mem_out.write && mem_out.wdata == $past(legacy_instr_ptr_q)) else $error("bad push");
  ldvt_quick_a: assert property (!busy_q && cmd_in == CMD_LDVT |=> !busy_q && !mem_out.valid)
    else $error("table load slow");
  hold_req_a: assert property (mem_out.valid && !mem_ready |=> mem_out.valid && $stable(mem_out.addr))
    else $error("request dropped");
  busy_end_a: assert property ($rose(busy_q) |-> ##[1:200] !busy_q)
    else $error("sequence hangs");
  cover property (ok_fetch && !bit20_wrap_mask_n);
  cover property (fault_q);
  cover property (!busy_q && cmd_in == CMD_INT);
endmodule : rmu_core_chk

bind rmu_core rmu_core_chk chk_i (.mclk(mclk), .srst(srst), .acc_in(acc_in), .bit20_wrap_mask_n(bit20_wrap_mask_n),
  .cmd_in(cmd_in), .mem_ready(mem_ready), .mem_out(mem_out), .mode_q(mode_q), .fault_q(fault_q),
  .fault_vec_q(fault_vec_q), .busy_q(busy_q), .fpu_en_q(fpu_en_q), .legacy_instr_ptr_q(legacy_instr_ptr_q),
  .code_seg_q(code_seg_q));

// ---- verif/rmu_mem_model.sv ----
// rmu_mem_model: memory on the physical path, answers after a set delay
module rmu_mem_model
  import rmu_pkg::*;
(
  input wire logic mclk,
  input rmu_mem_t mem_out,
  input wire logic [3:0] lat,
  output logic mem_ready = 1'b0,
  output logic [15:0] mem_rdata = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ram [int]; // sparse store keyed by byte address
  int cnt = 0;
  // one ready pulse per request; data toggles except on read answers so stale reads show
  always @(posedge mclk) begin
    mem_ready <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_out.valid && !mem_ready) begin
      if (cnt >= lat) begin
        cnt <= 0;
        mem_ready <= 1'b1;
        if (mem_out.write) ram[mem_out.addr] = mem_out.wdata;
        else mem_rdata <= ram.exists(mem_out.addr) ? ram[mem_out.addr] : 16'hDEAD;
      end else cnt <= cnt + 1;
    end
  end
endmodule : rmu_mem_model

// ---- verif/real_mode_address_and_stack_unit_test.sv ----
// real_mode_address_and_stack_unit_test: directed bench for rmu_core
module real_mode_address_and_stack_unit_test
  import rmu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SSB = 0; // stack selector assumed zero after reset
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic mask_n = 1'b1;
  logic mem_ready;
  rmu_acc_t acc = '0;
  rmu_cmd_t cmd = CMD_NONE;
  logic [31:0] tgt = '0;
  logic [15:0] sel = '0;
  logic [7:0] vec = '0;
  logic [3:0] lat = 4'h0;
  logic [1:0] opsz = 2'h1;
  logic op32 = 1'b0;
  logic [15:0] rdata, ip, flags, sp, cs;
  rmu_mem_t mo;
  rmu_mode_t mode;
  logic flt, busy, fpu, wide;
  logic [7:0] fvec;
  int error_cnt = 0;
  int checks = 0;
  always #2.5 mclk = ~mclk;
  rmu_core uut (.mclk(mclk), .srst(srst), .acc_in(acc), .bit20_wrap_mask_n(mask_n), .op_size_in(opsz),
    .op32_prefix(op32), .cmd_in(cmd), .cmd_target(tgt), .cmd_sel(sel), .cmd_vector(vec), .mem_ready(mem_ready),
    .mem_rdata(rdata), .mem_out(mo), .mode_q(mode), .fault_q(flt), .fault_vec_q(fvec), .busy_q(busy),
    .op_wide_q(wide), .fpu_en_q(fpu), .legacy_instr_ptr_q(ip), .status_word_q(flags), .stack_offset_q(sp),
    .code_seg_q(cs));
  rmu_mem_model mem (.mclk(mclk), .mem_out(mo), .lat(lat), .mem_ready(mem_ready), .mem_rdata(rdata));
  // ==========================================
  // helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  // command, then wait out busy; views lag one cycle, so settle two
  task automatic run(input rmu_cmd_t c, input logic [31:0] t, input logic [15:0] s, input logic [7:0] v);
    int n;
    n = 0;
    cmd = c;
    tgt = t;
    sel = s;
    vec = v;
    tick(1);
    cmd = CMD_NONE;
    while (busy === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (busy !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH t=%0t command never finished", $time);
    end
    tick(2);
  endtask : run
  // one-cycle access; caller checks the answer in the following cycle
  task automatic access(input rmu_seg_t s, input logic f, input logic [31:0] ofs);
    acc = '{valid: 1'b1, is_fetch: f, addr32: 1'b1, seg: s, offset: ofs};
    tick(1);
    acc.valid = 1'b0;
  endtask : access
  task automatic finish_acc(input string name);
    int n;
    n = 0;
    while ((mo.valid === 1'b1 || busy === 1'b1) && n < 50) begin
      tick(1);
      n++;
    end
    if (mo.valid !== 1'b0 || busy !== 1'b0) begin
      error_cnt++;
      $display("MISMATCH t=%0t access never finished", $time);
    end
    tick(1);
    $display("test %s done", name);
  endtask : finish_acc
  // ==========================================
  // scenarios
  task automatic t_reset();
    chk(mode, MODE_REAL, "mode");
    chk(fpu, 1'b1, "fpu");
    chk(wide, 1'b0, "narrow after reset");
    chk(ip, IP_RST[15:0], "ip");
    chk(flags, FLAGS_RST[15:0], "flags");
    chk(cs, CODE_SEL_RST, "cs");
    access(SEG_CODE, 1'b1, 32'h00000010);
    chk({mo.valid, mo.write, mo.addr}, {2'b10, 21'h0F0010}, "fetch");
    finish_acc("reset");
  endtask : t_reset
  task automatic t_calls();
    run(CMD_CALL_NEAR, 32'h00001234, 16'h0000, 8'h00);
    chk({sp, ip}, 32'hFFFE1234, "near call");
    chk(mem.ram[SSB + 'hFFFE], 16'hFFF0, "ip pushed");
    lat = 4'h3;
    run(CMD_CALL_FAR, 32'h00000000, 16'hFFFF, 8'h00);
    chk({sp, cs}, 32'hFFFAFFFF, "far call");
    chk({mem.ram[SSB + 'hFFFC], mem.ram[SSB + 'hFFFA]}, 32'hF0001234, "far frame");
    $display("test calls done");
  endtask : t_calls
  task automatic t_wrap();
    access(SEG_CODE, 1'b1, 32'h0000FFFF);
    chk(mo.addr, 21'h10FFEF, "carry kept");
    finish_acc("carry");
    mask_n = 1'b0;
    access(SEG_CODE, 1'b1, 32'h0000FFFF);
    chk(mo.addr, 21'h00FFEF, "masked");
    finish_acc("mask");
    access(SEG_CODE, 1'b1, 32'h00000001);
    chk(mo.addr, 21'h0FFFF1, "low bits kept");
    mask_n = 1'b1;
    finish_acc("low");
  endtask : t_wrap
  task automatic t_int();
    run(CMD_INT, 32'h0, 16'h0, 8'h03);
    chk({ip, cs, sp}, 48'h40002000FFF4, "vector 3");
    chk({mem.ram[SSB + 'hFFF8], mem.ram[SSB + 'hFFF6], mem.ram[SSB + 'hFFF4]}, 48'h0002FFFF0000, "frame");
    mem.ram[SSB + 'hFFF8] = 16'h0202;
    run(CMD_HANDLER_RETURN, 32'h0, 16'h0, 8'h00);
    chk({ip, cs, flags, sp}, 64'h0000FFFF0202FFFA, "handler return");
    run(CMD_RET_FAR, 32'h0, 16'h0, 8'h00);
    chk({ip, cs, sp}, 48'h1234F000FFFE, "far return");
    run(CMD_RET_NEAR, 32'h0, 16'h0, 8'h00);
    chk({ip, sp}, 32'hFFF00000, "near return");
    $display("test interrupt done");
  endtask : t_int
  task automatic t_vtab();
    lat = 4'h0;
    run(CMD_LDVT, 32'h00000100, 16'h0, 8'h00);
    run(CMD_INT, 32'h0, 16'h0, 8'h01);
    chk({ip, cs, sp}, 48'h50003000FFFA, "moved table");
    chk(mem.ram[SSB + 'hFFFE], 16'h0202, "low flags pushed");
    $display("test table done");
  endtask : t_vtab
  task automatic t_fault();
    access(SEG_DATA, 1'b0, 32'h00010000);
    chk({flt, fvec, mo.valid}, {1'b1, VEC_GEN_FLT, 1'b0}, "data overrun");
    tick(1);
    chk(flt, 1'b0, "pulse");
    access(SEG_STACK, 1'b0, 32'hFFFFFFFF);
    chk({flt, fvec, mo.valid}, {1'b1, VEC_STACK_FLT, 1'b0}, "stack overrun");
    tick(1);
    access(SEG_DATA, 1'b0, 32'h0000FFFF);
    chk({flt, mo.valid}, 2'b01, "limit legal");
    finish_acc("fault");
  endtask : t_fault
  // operand width: wide only for a dword with the prefix; overruns keep the bus quiet
  task automatic t_width();
    op32 = 1'b1;
    opsz = 2'h2;
    access(SEG_DATA, 1'b0, 32'h00010000);
    chk(wide, 1'b1, "prefixed dword");
    tick(1);
    opsz = 2'h1;
    access(SEG_DATA, 1'b0, 32'h00010000);
    chk(wide, 1'b0, "prefixed word");
    tick(1);
    op32 = 1'b0;
    opsz = 2'h2;
    access(SEG_DATA, 1'b0, 32'h00010000);
    chk(wide, 1'b0, "dword without prefix");
    opsz = 2'h1;
    tick(1);
    $display("test width done");
  endtask : t_width
  // ==========================================
  // verdict
  task automatic conclude();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  initial begin
    mem.ram[12] = 16'h4000;
    mem.ram[14] = 16'h2000;
    mem.ram[32'h104] = 16'h5000;
    mem.ram[32'h106] = 16'h3000;
    repeat (12) @(posedge mclk);
    #1 srst = 1'b0;
    tick(1);
    t_reset();
    t_calls();
    t_wrap();
    t_int();
    t_vtab();
    t_fault();
    t_width();
    conclude();
  end
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude();
  end
endmodule : real_mode_address_and_stack_unit_test
